// ### hdl/pll_clk_map.svh
// Register offsets, field positions, reset values and timing counts of the clock block
`ifndef PLL_CLK_MAP_SVH
`define PLL_CLK_MAP_SVH
`define CTRL_IDX 8'hd7
`define STAT_IDX 8'hd8
`define MASK_IDX 8'hd9
`define CTRL_ADDR 12'h35c
`define STAT_ADDR 12'h360
`define MASK_ADDR 12'h364
`define CTRL_RESET 8'h53
`define CTRL_WMASK 8'hbf
`define CTRL_DIRECT_MASK 8'h07
`define HALT_BIT 7
`define LOCK_BIT 6
`define DIV_LSB 0
`define DIV_MSB 2
`define DIV_RESET 3'h3
`define STAT_GAIN_BIT 0
`define STAT_LOSS_BIT 1
`define LOOP_MULT 13'h0200
`define PCLK_HZ 25000000
`define XTAL_HZ 32768
`define REF_PERIOD_CYC (`PCLK_HZ / `XTAL_HZ)
`define LOCK_TOL_CYC 16
`define REF_TIMEOUT_CYC (2 * `REF_PERIOD_CYC)
`endif

// ### hdl/pll_clk_pkg.sv
// Types shared by the clock block
package pll_clk_pkg;
  typedef enum logic [0:0] {
    LOOP_RAILED = 1'b0,
    LOOP_TRACKING = 1'b1
  } loop_state_type;
endpackage

// ### hdl/core_clock_divider.sv
// Binary divider of the loop output, changing ratio only at a period boundary
`timescale 1ns/1ns
`default_nettype none
`include "pll_clk_map.svh"
module core_clock_divider (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic loop_tick, // One pulse per loop output period
  input wire logic [2:0] divide_sel, // Requested power-of-two exponent
  output logic core_tick, // Core clock enable pulse
  output logic core_phase, // Core clock level, toggles per core tick
  output logic [2:0] divide_applied // Exponent now in force
);
  logic [6:0] cnt_r;
  logic core_tick_r;
  logic core_phase_r;
  logic [2:0] cd_act_r;
  wire [6:0] last_count = (7'h01 << cd_act_r) - 7'h01;
  wire at_last = (cnt_r == last_count);

  // Ratio swaps only on the last loop tick of a period, so no runt core pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 7'h00;
      cd_act_r <= `DIV_RESET; // R3
      core_tick_r <= 1'b0;
      core_phase_r <= 1'b0;
    end else begin
      core_tick_r <= loop_tick & at_last; // R2
      if (loop_tick) begin
        if (at_last) begin
          cnt_r <= 7'h00;
          cd_act_r <= divide_sel; // R10
          core_phase_r <= ~core_phase_r;
        end else begin
          cnt_r <= cnt_r + 7'h01;
        end
      end
    end
  end

  assign core_tick = core_tick_r;
  assign core_phase = core_phase_r;
  assign divide_applied = cd_act_r;

  div_boundary_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (cd_act_r != $past(cd_act_r)) |-> $past(loop_tick && at_last))
    else $error("divider ratio changed inside a core period");
  core_tick_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
    core_tick_r |-> $past(loop_tick) && $past(cnt_r) == $past(last_count))
    else $error("core tick not at end of divided period");
endmodule
`default_nettype wire

// ### hdl/pll_core_clock_divider.sv
// Loop multiplier model, core clock divider control and APB registers
// Function
// R1: Loop output runs at 512 times the watch-crystal reference frequency.
// R2: Core clock is loop output or a binary submultiple chosen by divider field.
// R3: After reset the core clock is loop output divided by 8.
// R4: Modulator clock runs at crystal rate, aligned with the loop output.
// R5: Direct-crystal variant: core speed is crystal divided by two to the field.
// R6: Direct-crystal variant: software writes zero to all non-divider bits.
// R7: Low-voltage parts: software never programs divider value zero.
// R8: Read-only lock flag set while loop tracks crystal, clear otherwise.
// R9: Oscillator runs in power-down unless the halt bit is set.
// R10: New divider setting takes effect only at a core clock boundary.
`timescale 1ns/1ns
`default_nettype none
`include "pll_clk_map.svh"
module pll_core_clock_divider
  import pll_clk_pkg::*;
#(
  parameter bit DIRECT_XTAL = 1'b0, // Variant clocked straight from a crystal
  parameter int REF_PERIOD = `REF_PERIOD_CYC, // Nominal pclk cycles per reference
  parameter int LOCK_TOL = `LOCK_TOL_CYC, // Accepted deviation of a period
  parameter int REF_TIMEOUT = `REF_TIMEOUT_CYC // Reference silence before lock loss
) (
  input wire logic pclk, // Bus and system clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic xtal_ref, // Crystal reference level
  input wire logic powerdown, // Chip in power-down
  output logic loop_tick, // Loop output pulse
  output logic core_tick, // Core clock enable pulse
  output logic core_phase, // Core clock level
  output logic modulator_tick, // Converter modulator clock pulse
  output logic osc_running, // Crystal oscillator enable
  output logic irq // Level interrupt
);
  logic [7:0] ctrl_r;
  logic [1:0] stat_r;
  logic [1:0] mask_r;
  logic [31:0] prdata_r;
  logic ref_d_r;
  logic seen_r;
  logic [11:0] period_cnt_r;
  logic [11:0] period_r;
  logic [12:0] acc_r;
  logic loop_tick_r;
  logic [8:0] mult_cnt_r;
  logic mod_tick_r;
  logic osc_run_r;
  logic first_r;
  loop_state_type loop_state_r;
  loop_state_type loop_state_nxt;
  logic [2:0] divide_applied;

  function automatic logic [1:0] decode_addr(input logic [11:0] a);
    logic [1:0] d;
    d = 2'd3;
    if (a == `CTRL_ADDR) d = 2'd0;
    if (a == `STAT_ADDR) d = 2'd1;
    if (a == `MASK_ADDR) d = 2'd2;
    return d;
  endfunction

  wire [1:0] sel = decode_addr(paddr);
  wire hit = (sel != 2'd3);
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite & hit;
  wire wr_ctrl = wr & (sel == 2'd0);
  wire wr_stat = wr & (sel == 2'd1);
  wire wr_mask = wr & (sel == 2'd2);
  wire locked = (loop_state_r == LOOP_TRACKING) & ~DIRECT_XTAL; // R8

  // Direct variant keeps only the divider; other bits are not stored
  wire [7:0] ctrl_wmask = DIRECT_XTAL ? `CTRL_DIRECT_MASK : `CTRL_WMASK; // R5
  wire [7:0] ctrl_rd = (ctrl_r & ctrl_wmask) | {1'b0, locked, 6'h00}; // R8
  wire [7:0] ctrl_nxt = (ctrl_r & ~ctrl_wmask) | (pwdata[7:0] & ctrl_wmask);
  wire [2:0] divide_sel = ctrl_r[`DIV_MSB:`DIV_LSB]; // R2 R5
  wire halt_in_pd = ctrl_r[`HALT_BIT] & ~DIRECT_XTAL;

  wire [31:0] rd_mux = (sel == 2'd0) ? {24'h000000, ctrl_rd} :
                       (sel == 2'd1) ? {30'h0, stat_r} :
                       (sel == 2'd2) ? {30'h0, mask_r} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CTRL_RESET; // R3
      mask_r <= 2'h0;
      prdata_r <= 32'h00000000;
      first_r <= 1'b0;
    end else begin
      first_r <= 1'b1;
      if (wr_ctrl) ctrl_r <= ctrl_nxt;
      if (wr_mask) mask_r <= pwdata[1:0];
      if (setup) prdata_r <= rd_mux;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = access & ~hit;

  // Reference period measurement and lock tracking
  wire ref_edge = xtal_ref & ~ref_d_r;
  // First edge only starts the count; time since reset is not a period
  wire judge = ref_edge & seen_r;
  wire [11:0] lo_lim = 12'(REF_PERIOD - LOCK_TOL);
  wire [11:0] hi_lim = 12'(REF_PERIOD + LOCK_TOL);
  wire in_window = (period_cnt_r >= lo_lim) && (period_cnt_r <= hi_lim);
  wire timed_out = (period_cnt_r == 12'(REF_TIMEOUT));

  always_comb begin
    loop_state_nxt = loop_state_r;
    case (loop_state_r)
      LOOP_TRACKING: begin
        if (timed_out || (judge && !in_window)) loop_state_nxt = LOOP_RAILED;
      end
      LOOP_RAILED: begin
        if (judge && in_window) loop_state_nxt = LOOP_TRACKING;
      end
      default: loop_state_nxt = LOOP_RAILED;
    endcase
  end

  wire gained = (loop_state_r == LOOP_RAILED) & (loop_state_nxt == LOOP_TRACKING);
  wire lost = (loop_state_r == LOOP_TRACKING) & (loop_state_nxt == LOOP_RAILED);
  wire [1:0] events = DIRECT_XTAL ? 2'b00 : {lost, gained};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // High at reset, so a reference already high at release is no edge
      ref_d_r <= 1'b1;
      seen_r <= 1'b0;
      period_cnt_r <= 12'h000;
      period_r <= 12'(REF_PERIOD);
      loop_state_r <= LOOP_TRACKING;
      stat_r <= 2'h0;
    end else begin
      ref_d_r <= xtal_ref;
      loop_state_r <= loop_state_nxt; // R8
      if (ref_edge) begin
        seen_r <= 1'b1;
        period_cnt_r <= 12'h001;
        if (judge && in_window) period_r <= period_cnt_r;
      end else if (!timed_out) begin
        period_cnt_r <= period_cnt_r + 12'h001;
      end
      // Set wins over a write-one clear in the same cycle
      stat_r <= (stat_r & ~(wr_stat ? pwdata[1:0] : 2'h0)) | events;
    end
  end

  assign irq = |(stat_r & mask_r);

  // Loop output: 512 ticks per measured reference period; holds the last accepted period when lost
  wire [12:0] acc_sum = acc_r + `LOOP_MULT;
  wire acc_tick = (acc_sum >= {1'b0, period_r});
  wire loop_pulse = DIRECT_XTAL ? ref_edge : acc_tick; // R5
  wire mult_wrap = (mult_cnt_r == 9'h1ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= 13'h0000;
      loop_tick_r <= 1'b0;
      mult_cnt_r <= 9'h000;
      mod_tick_r <= 1'b0;
      osc_run_r <= 1'b1;
    end else begin
      acc_r <= acc_tick ? (acc_sum - {1'b0, period_r}) : acc_sum; // R1
      loop_tick_r <= loop_pulse;
      if (loop_tick_r) mult_cnt_r <= mult_cnt_r + 9'h001; // R1
      // Modulator ticks once per 512 loop ticks, or on every reference edge in the direct variant, so it stays in step with the loop output
      mod_tick_r <= DIRECT_XTAL ? ref_edge : (loop_tick_r & mult_wrap); // R4
      osc_run_r <= ~(powerdown & halt_in_pd); // R9
    end
  end

  assign loop_tick = loop_tick_r;
  assign modulator_tick = mod_tick_r;
  assign osc_running = osc_run_r;

  // Divider value zero is legal here; low-voltage parts rely on software
  core_clock_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .loop_tick(loop_tick_r),
    .divide_sel(divide_sel),
    .core_tick(core_tick),
    .core_phase(core_phase),
    .divide_applied(divide_applied)
  );

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  mod_rate_a: assert property ( // R4
    !DIRECT_XTAL && mod_tick_r |-> $past(loop_tick_r) && $past(mult_cnt_r) == 9'h1ff)
    else $error("modulator tick not on 512th loop tick");
  loop_ratio_a: assert property ( // R1
    !DIRECT_XTAL && loop_tick_r |=> !loop_tick_r || ({1'b0, period_r} < (`LOOP_MULT << 1)))
    else $error("loop ticks back to back at nominal period");
  lock_loss_a: assert property ( // R8
    !DIRECT_XTAL && timed_out && locked |=> !locked ##1 stat_r[`STAT_LOSS_BIT])
    else $error("silent reference did not drop lock");
  lock_gain_a: assert property ( // R8
    !DIRECT_XTAL && !locked && judge && in_window |=> locked)
    else $error("lock not regained on good period");
  reset_div_a: assert property ( // R3
    !first_r |-> ctrl_r[`DIV_MSB:`DIV_LSB] == `DIV_RESET && divide_applied == `DIV_RESET)
    else $error("divider not at eight after reset");
  div_hold_a: assert property ( // R2
    !wr_ctrl |=> ctrl_r[`DIV_MSB:`DIV_LSB] == $past(ctrl_r[`DIV_MSB:`DIV_LSB]))
    else $error("divider field moved without a write");
  osc_halt_a: assert property ( // R9
    powerdown && halt_in_pd |=> !osc_run_r)
    else $error("oscillator kept running with halt set");
  osc_keep_a: assert property ( // R9
    !(powerdown && halt_in_pd) |=> osc_run_r)
    else $error("oscillator stopped without halt in power-down");
  direct_bits_a: assert property ( // R5
    DIRECT_XTAL |-> ctrl_rd[7:3] == 5'h00)
    else $error("reserved bits visible on direct variant");
  irq_level_a: assert property (
    (stat_r & mask_r) != 2'h0 |-> irq ##1 (irq || $past(wr_stat) || $past(wr_mask)))
    else $error("interrupt dropped without clear or mask");
endmodule
`default_nettype wire

// ### verif/pll_core_clock_divider_tb.sv
// Self-checking bench of the clock block: registers, divider, lock, interrupt
`timescale 1ns/1ns
`default_nettype none
`include "pll_clk_map.svh"
module pll_core_clock_divider_tb;
  localparam int RP = 1024;
  localparam int TO = 2048;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic xtal_ref = 1'b0;
  logic powerdown = 1'b0;
  logic ref_on = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, loop_tick, core_tick, core_phase, modulator_tick, osc_running, irq;
  logic [31:0] prdata_x;
  logic pready_x, pslverr_x, core_tick_x, modulator_tick_x, irq_x;
  logic tgt = 1'b0;
  logic xtal_x = 1'b0;
  logic ph = 1'b0;
  logic [31:0] seed = 32'h2f;
  logic [31:0] exp_q[$];
  logic er;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int rc = 0;
  int lcnt = 0;
  int mcnt = 0;
  int g, e;
  // Bus goes to the direct-crystal instance while tgt is high
  wire psel_m = psel & ~tgt;
  wire psel_x = psel & tgt;
  wire [31:0] rdata = tgt ? prdata_x : prdata;
  wire rdy = tgt ? pready_x : pready;
  wire serr = tgt ? pslverr_x : pslverr;

  // Reference period is twice the loop multiplier of 512 so loop ticks land every second cycle
  pll_core_clock_divider #(.REF_PERIOD(RP), .LOCK_TOL(16), .REF_TIMEOUT(TO))
    i_pll_core_clock_divider (
    .pclk(pclk), .presetn(presetn), .psel(psel_m), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xtal_ref(xtal_ref), .powerdown(powerdown), .loop_tick(loop_tick), .core_tick(core_tick),
    .core_phase(core_phase), .modulator_tick(modulator_tick), .osc_running(osc_running),
    .irq(irq));

  // Direct-crystal variant on its own fast reference: one loop tick per 8 cycles
  pll_core_clock_divider #(.DIRECT_XTAL(1'b1)) i_pll_core_clock_divider_direct (
    .pclk(pclk), .presetn(presetn), .psel(psel_x), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata_x), .pready(pready_x),
    .pslverr(pslverr_x), .xtal_ref(xtal_x), .powerdown(powerdown),
    .loop_tick(), .core_tick(core_tick_x), .core_phase(),
    .modulator_tick(modulator_tick_x), .osc_running(), .irq(irq_x));

  initial forever #20 pclk = ~pclk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    checked++;
    if (s !== x) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Loop ticks per core period and per modulator period; read data against the oldest note
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    rc <= (rc == RP - 1) ? 0 : rc + 1;
    xtal_ref <= ref_on && (rc < RP / 2);
    xtal_x <= rc[2];
    lcnt <= core_tick ? int'(loop_tick) : lcnt + int'(loop_tick);
    mcnt <= modulator_tick ? int'(loop_tick) : mcnt + int'(loop_tick);
    if (psel && penable && rdy === 1'b1 && !pwrite) begin
      chk("prdata", exp_q.pop_front(), rdata);
    end
    // Core clock level flips with every core tick
    if (core_tick === 1'b1) begin
      ph = ~ph;
      chk("core_phase", {31'h0, ph}, {31'h0, core_phase});
    end
    if (cyc == 40000) begin
      err_count++;
      results();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (rdy !== 1'b1);
    er = serr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wcore(output int gap);
    @(posedge pclk iff core_tick);
    gap = lcnt;
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CTRL_ADDR, 32'h53);
    rd(`STAT_ADDR, 32'h0);
    rd(`MASK_ADDR, 32'h0);
    // A good reference after reset raises no lock event
    repeat (4 * RP) @(posedge pclk);
    rd(`STAT_ADDR, 32'h0);
    apb(1'b1, `STAT_ADDR, 32'h3);
    rd(`CTRL_ADDR, 32'h53);
    @(posedge pclk iff modulator_tick);
    e = cyc;
    @(posedge pclk iff modulator_tick);
    chk("mod_loop_ticks", 32'h200, 32'(mcnt));
    chk("mod_period", 32'(RP), 32'(cyc - e));
    $display("test reset and loop done");
    // Divider zero is written: this bench stands for a full-voltage part
    for (int d = 7; d >= 0; d--) begin
      int o;
      o = (d == 7) ? 3 : d + 1;
      @(posedge pclk iff core_tick);
      e = int'((xs() & 32'hffffff78) | 32'(d));
      apb(1'b1, `CTRL_ADDR, 32'(e));
      wcore(g);
      // Periods of one or two loop ticks are shorter than a bus write
      if (o > 1) chk("gap_old", 32'(1 << o), 32'(g));
      wcore(g);
      wcore(g);
      chk("gap_new", 32'(1 << d), 32'(g));
      rd(`CTRL_ADDR, (32'(e) & 32'h38) | 32'h40 | 32'(d));
    end
    $display("test divider done");
    apb(1'b1, `CTRL_ADDR, 32'h83);
    powerdown <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("osc_halted", 32'h0, {31'h0, osc_running});
    apb(1'b1, `CTRL_ADDR, 32'h03);
    repeat (3) @(posedge pclk);
    chk("osc_kept", 32'h1, {31'h0, osc_running});
    powerdown <= 1'b0;
    rd(12'h000, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    $display("test power-down and unmapped done");
    apb(1'b1, `MASK_ADDR, 32'h3);
    ref_on <= 1'b0;
    repeat (TO + RP + 10) @(posedge pclk);
    rd(`STAT_ADDR, 32'h2);
    rd(`CTRL_ADDR, 32'h03);
    chk("irq_lost", 32'h1, {31'h0, irq});
    apb(1'b1, `MASK_ADDR, 32'h1);
    @(negedge pclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, `STAT_ADDR, 32'h2);
    rd(`STAT_ADDR, 32'h0);
    ref_on <= 1'b1;
    repeat (4 * RP) @(posedge pclk);
    rd(`STAT_ADDR, 32'h1);
    rd(`CTRL_ADDR, 32'h43);
    @(negedge pclk);
    chk("irq_gain", 32'h1, {31'h0, irq});
    $display("test lock and interrupt done");
    @(posedge pclk);
    tgt <= 1'b1;
    rd(`CTRL_ADDR, 32'h03);
    // Only the divider field is written on the direct variant
    apb(1'b1, `CTRL_ADDR, 32'h02);
    rd(`CTRL_ADDR, 32'h02);
    rd(`STAT_ADDR, 32'h0);
    @(posedge pclk iff modulator_tick_x);
    e = cyc;
    @(posedge pclk iff modulator_tick_x);
    chk("mod_direct", 32'h8, 32'(cyc - e));
    repeat (2) @(posedge pclk iff core_tick_x);
    e = cyc;
    @(posedge pclk iff core_tick_x);
    chk("core_direct", 32'h20, 32'(cyc - e));
    chk("irq_direct", 32'h0, {31'h0, irq_x});
    $display("test direct variant done");
    results();
  end
endmodule
`default_nettype wire
